// ---- hw/ssrs_top.sv ----
// synchronous serial port with single-byte and RAM streaming modes
module ssrs_top (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic core_ce,
    input wire logic cpu_halt,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_n,
    output logic data_out_pin,
    output logic data_out_pin_oe_n,
    input wire logic data_inout_pin_in,
    output logic data_inout_pin_out,
    output logic data_inout_pin_oe_n,
    output logic done_irq,
    output logic halt_wake
);
    import ssrs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ssrs_ctrl_type ctrl;          // control and status bits
        logic [7:0] shift_buffer;     // serial shift register
        logic [7:0] baud_reload;      // internal clock half period minus one
        logic [7:0] bit_length_reg;   // continuous length minus one
        ssrs_stream_type stream;      // pause, user bits, byte count
        logic [1:0] pincfg;           // external clock, two-wire
        ssrs_phase_type phase;        // sequencer phase
        logic [7:0] bits_left;        // bits still to move after current one
        logic [2:0] bit_idx;          // bit position within current byte
        logic [4:0] ram_idx;          // next RAM byte within bank
        logic [7:0] baud_cnt;         // internal clock divider
        logic sclk;                   // internal clock level
        logic sclk_prev;              // last synchronised external clock
        logic cont_run;               // last finished run was continuous
        logic waitreq;                // bus waitrequest
        logic [31:0] rdata;           // bus read data
        logic dout;                   // serial data output level
        logic dio_oe_n;               // open-drain pull-down enable
        logic irq;                    // completion interrupt request
        logic wake;                   // halt release request
    } ssrs_state_type;

    ssrs_state_type st;
    ssrs_state_type nx;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bit presented on the line next, per order select
    function automatic logic out_bit(input logic [7:0] sb, input logic msb);
        out_bit = msb ? sb[7] : sb[0];
    endfunction : out_bit

    // true when a bus index falls inside the data RAM window
    function automatic logic is_ram(input logic [15:0] idx);
        is_ram = (idx >= IDX_RAM_LO) && (idx <= IDX_RAM_HI);
    endfunction : is_ram

    // ------------------------------------------------------------
    // pin synchronisers and RAM
    // ------------------------------------------------------------
    logic [1:0] pins_sync;    // {clock, data} settled in core domain
    logic sclk_s;             // settled external clock
    logic din_s;              // settled data line
    logic [7:0] bus_ram_rdata;
    logic [7:0] seq_ram_rdata;
    logic bus_ram_we;         // bus write into RAM window
    logic seq_ram_we;         // write-back during exchange

    ssrs_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .core_ce(core_ce),
        .async_in({serial_clock_pin_in, data_inout_pin_in}),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[1];
    assign din_s = pins_sync[0];

    ssrs_ram u_ram (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .core_ce(core_ce),
        .bus_addr(avs_address[5:0]),
        .bus_we(bus_ram_we),
        .bus_wdata(avs_writedata[7:0]),
        .bus_rdata(bus_ram_rdata),
        .seq_addr({st.ctrl.ram_bank_select, st.ram_idx}),
        .seq_we(seq_ram_we),
        .seq_wdata(st.shift_buffer),
        .seq_rdata(seq_ram_rdata)
    );

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    logic [31:0] read_value;   // value for the addressed register

    always_comb begin
        read_value = 32'h0000_0000;
        case (avs_address)
            IDX_CTRL: read_value[7:0] = st.ctrl;
            IDX_SHIFT: read_value[7:0] = st.shift_buffer;
            IDX_BAUD: read_value[7:0] = st.baud_reload;
            IDX_BITLEN: read_value[7:0] = st.bit_length_reg;
            IDX_STREAM: read_value[7:0] = st.stream;
            IDX_PINCFG: read_value[1:0] = st.pincfg;
            default: begin
                if (is_ram(avs_address)) begin
                    read_value[7:0] = bus_ram_rdata;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic ext_clk;    // clock comes from the pin
    logic fall_ev;    // serial clock falling edge this cycle
    logic rise_ev;    // serial clock rising edge this cycle
    logic accept_wr;  // bus write completes at this edge
    logic held;       // exchange held back by halt or pause

    always_comb begin
        nx = st;
        ext_clk = st.pincfg[PINCFG_EXT_CLK];
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        bus_ram_we = 1'b0;
        seq_ram_we = 1'b0;
        held = 1'b0;
        accept_wr = avs_write && !st.waitreq;

        // bus handshake: one wait cycle, then the access completes
        if ((avs_read || avs_write) && st.waitreq) begin
            nx.waitreq = 1'b0;
            nx.rdata = read_value;
        end else begin
            nx.waitreq = 1'b1;
        end

        // bus writes, applied before hardware updates so hardware sets win
        if (accept_wr) begin
            case (avs_address)
                IDX_CTRL: nx.ctrl = avs_writedata[7:0];
                IDX_SHIFT: nx.shift_buffer = avs_writedata[7:0];
                IDX_BAUD: nx.baud_reload = avs_writedata[7:0];
                IDX_BITLEN: nx.bit_length_reg = avs_writedata[7:0];
                IDX_STREAM: begin
                    // byte count is read only
                    nx.stream.byte_pause = avs_writedata[7];
                    nx.stream.user_bits = avs_writedata[6:5];
                end
                IDX_PINCFG: nx.pincfg = avs_writedata[1:0];
                default: bus_ram_we = is_ram(avs_address);
            endcase
        end

        // serial clock edges: pin edges or internal divider ticks
        nx.sclk_prev = sclk_s;
        if (ext_clk) begin
            fall_ev = st.sclk_prev && !sclk_s;
            rise_ev = !st.sclk_prev && sclk_s;
        end else if (st.phase == PH_SHIFT) begin
            if (st.baud_cnt == 8'h00) begin
                nx.baud_cnt = st.baud_reload;
                nx.sclk = !st.sclk;
                fall_ev = st.sclk;
                rise_ev = !st.sclk;
            end else begin
                nx.baud_cnt = st.baud_cnt - 8'h01;
            end
        end

        // sequencer
        case (st.phase)
            PH_IDLE: begin
                if (ext_clk && fall_ev) begin
                    nx.ctrl.overrun_flag = 1'b1;
                end
                if (nx.ctrl.run_flag) begin
                    nx.ram_idx = 5'h00;
                    nx.bit_idx = 3'h0;
                    nx.sclk = 1'b1;
                    nx.baud_cnt = nx.baud_reload;
                    if (nx.ctrl.continuous_mode) begin
                        nx.phase = PH_XCHG;
                        nx.bits_left = nx.bit_length_reg;
                        nx.stream.byte_count = 5'h00;
                    end else begin
                        nx.phase = PH_SHIFT;
                        nx.bits_left = SINGLE_LAST_BIT;
                        nx.dout = out_bit(nx.shift_buffer, nx.ctrl.msb_first_select);
                    end
                end
            end
            PH_XCHG: begin
                if (ext_clk && fall_ev) begin
                    nx.ctrl.overrun_flag = 1'b1;
                end
                // halt holds the port before the exchange
                // pause holds after a completed byte
                held = cpu_halt || (st.stream.byte_pause && (st.ram_idx != 5'h00));
                if (!held) begin
                    // copy, or swap when write-back is on
                    nx.shift_buffer = seq_ram_rdata;
                    seq_ram_we = st.ctrl.ram_writeback_enable;
                    nx.ram_idx = st.ram_idx + 5'h01;
                    nx.stream.byte_count = st.stream.byte_count + 5'h01;
                    nx.bit_idx = 3'h0;
                    nx.sclk = 1'b1;
                    nx.baud_cnt = st.baud_reload;
                    nx.phase = PH_SHIFT;
                    nx.dout = out_bit(seq_ram_rdata, st.ctrl.msb_first_select);
                end
            end
            PH_SHIFT: begin
                if (fall_ev) begin
                    nx.dout = out_bit(st.shift_buffer, st.ctrl.msb_first_select);
                end
                if (rise_ev) begin
                    if (st.ctrl.msb_first_select) begin
                        nx.shift_buffer = {st.shift_buffer[6:0], din_s};
                    end else begin
                        nx.shift_buffer = {din_s, st.shift_buffer[7:1]};
                    end
                    if (st.bits_left == 8'h00) begin
                        // last rising edge ends the run
                        // final bits remain in the buffer
                        nx.ctrl.done_flag = 1'b1;
                        nx.ctrl.run_flag = 1'b0;
                        nx.ctrl.continuous_mode = 1'b0;
                        nx.cont_run = st.ctrl.continuous_mode;
                        nx.sclk = 1'b1;
                        nx.phase = PH_IDLE;
                    end else begin
                        nx.bits_left = st.bits_left - 8'h01;
                        nx.bit_idx = st.bit_idx + 3'h1;
                        if (st.ctrl.continuous_mode && (st.bit_idx == BYTE_LAST_BIT)) begin
                            nx.phase = PH_XCHG;
                        end
                    end
                end
            end
            default: nx.phase = PH_IDLE;
        endcase

        // software clearing the run flag aborts a transfer
        if ((st.phase != PH_IDLE) && !nx.ctrl.run_flag) begin
            nx.phase = PH_IDLE;
            nx.sclk = 1'b1;
        end

        // two-wire: pull the shared line low for a zero
        nx.dio_oe_n = !(st.pincfg[PINCFG_TWO_WIRE] && (nx.phase != PH_IDLE) && !nx.dout);

        nx.irq = nx.ctrl.done_flag && nx.ctrl.done_irq_enable;
        nx.wake = nx.irq && !nx.cont_run;
    end

    // ------------------------------------------------------------
    // state register, frozen while the clock enable is low
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.shift_buffer <= BYTE_RESET;
            st.baud_reload <= BYTE_RESET;
            st.bit_length_reg <= BYTE_RESET;
            st.stream <= BYTE_RESET;
            st.pincfg <= PINCFG_RESET;
            st.phase <= PH_IDLE;
            st.sclk <= 1'b1;
            st.sclk_prev <= 1'b1;
            st.waitreq <= 1'b1;
            st.dout <= 1'b1;
            st.dio_oe_n <= 1'b1;
        end else if (core_ce) begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops except the data line drive, tied low
    // ------------------------------------------------------------
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign serial_clock_pin_out = st.sclk;
    // clock pin is an input with the external clock
    assign serial_clock_pin_oe_n = st.pincfg[PINCFG_EXT_CLK];
    assign data_out_pin = st.dout;
    // dedicated output used in three-wire mode only
    assign data_out_pin_oe_n = st.pincfg[PINCFG_TWO_WIRE];
    assign data_inout_pin_out = 1'b0;
    assign data_inout_pin_oe_n = st.dio_oe_n;
    assign done_irq = st.irq;
    assign halt_wake = st.wake;

endmodule : ssrs_top

// ---- hw/ssrs_pkg.sv ----
// constants and types shared by the serial RAM streamer files
package ssrs_pkg;

    // ------------------------------------------------------------
    // register indices (word address on the bus, byte address = 4 x index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CTRL = 16'hFE30;     // serial_control_reg
    localparam logic [15:0] IDX_SHIFT = 16'hFE31;    // shift_buffer
    localparam logic [15:0] IDX_BAUD = 16'hFE32;     // baud_reload
    localparam logic [15:0] IDX_BITLEN = 16'hFE33;   // bit_length_reg
    localparam logic [15:0] IDX_STREAM = 16'hFE37;   // stream_control_reg
    localparam logic [15:0] IDX_PINCFG = 16'hFE38;   // pin configuration
    localparam logic [15:0] IDX_RAM_LO = 16'h01C0;   // first byte of bank 0
    localparam logic [15:0] IDX_RAM_HI = 16'h01FF;   // last byte of bank 1

    // ------------------------------------------------------------
    // values after reset and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] PINCFG_RESET = 2'h0;
    localparam logic [7:0] SINGLE_LAST_BIT = 8'h07;   // single-byte run moves 8 bits
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;      // bit index of a byte's last bit
    localparam int RAM_WORDS = 64;                   // two banks of 32 bytes
    localparam int PINCFG_EXT_CLK = 0;               // field position: external clock
    localparam int PINCFG_TWO_WIRE = 1;              // field position: two-wire mode

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic ram_bank_select;
        logic ram_writeback_enable;
        logic run_flag;
        logic continuous_mode;
        logic msb_first_select;
        logic overrun_flag;
        logic done_flag;
        logic done_irq_enable;
    } ssrs_ctrl_type;

    // stream control register, bit 7 down to bit 0
    typedef struct packed {
        logic byte_pause;
        logic [1:0] user_bits;
        logic [4:0] byte_count;
    } ssrs_stream_type;

    // sequencer phases
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_XCHG = 2'b01,
        PH_SHIFT = 2'b10
    } ssrs_phase_type;

endpackage : ssrs_pkg

// ---- hw/ssrs_sync.sv ----
// two-flop synchroniser for pins entering the core clock domain
module ssrs_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic core_ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import ssrs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] stage1;   // first flop, read only by stage2
        logic [WIDTH-1:0] stage2;   // settled copy
    } ssrs_sync_state_type;

    ssrs_sync_state_type state_reg;
    ssrs_sync_state_type state_next;

    // next state: plain two-stage shift
    always_comb begin
        state_next = state_reg;
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
    end

    // register, frozen while the clock enable is low
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            // pins idle high, so no false clock edge follows reset
            state_reg <= '1;
        end else if (core_ce) begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage2;

endmodule : ssrs_sync

// ---- hw/ssrs_ram.sv ----
// 64-byte dual-port data RAM shared by software and the streamer
module ssrs_ram (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic core_ce,
    input wire logic [5:0] bus_addr,
    input wire logic bus_we,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [5:0] seq_addr,
    input wire logic seq_we,
    input wire logic [7:0] seq_wdata,
    output logic [7:0] seq_rdata
);
    import ssrs_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    typedef struct packed {
        logic [RAM_WORDS-1:0][7:0] mem;   // bank 0 low half, bank 1 high half
    } ssrs_ram_state_type;

    ssrs_ram_state_type state_reg;
    ssrs_ram_state_type state_next;

    // writes: the streamer wins if both hit the same byte in one cycle
    always_comb begin
        state_next = state_reg;
        if (bus_we) begin
            state_next.mem[bus_addr] = bus_wdata;
        end
        if (seq_we) begin
            state_next.mem[seq_addr] = seq_wdata;
        end
    end

    // register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else if (core_ce) begin
            state_reg <= state_next;
        end
    end

    // asynchronous reads so an exchange completes in one cycle
    assign bus_rdata = state_reg.mem[bus_addr];
    assign seq_rdata = state_reg.mem[seq_addr];

endmodule : ssrs_ram

// ---- bench/ssrs_partner.sv ----
// far-side serial device model: data source and optional external clock
module ssrs_partner (
    input wire logic line_clk,
    input wire logic ld,
    input wire logic go,
    input wire logic [7:0] val,
    output logic ext_clk,
    output logic sd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pat; // rotating pattern, msb sent first
    initial begin
        ext_clk = 1'b1;
        sd = 1'b1;
        pat = 8'hFF;
    end
    // pattern restarts on a load request
    always @(posedge ld) begin
        pat <= val;
    end
    // data changes on falls so the device samples it on rises
    always @(negedge line_clk) begin
        sd <= pat[7];
        pat <= {pat[6:0], pat[7]};
    end
    // external clock burst: 8 periods of 80 ns, idle high, edges kept off the core clock edge
    always @(posedge go) begin
        #1;
        repeat (8) begin
            #40 ext_clk = 1'b0;
            #40 ext_clk = 1'b1;
        end
    end
endmodule : ssrs_partner

// ---- bench/ssrs_top_chk.sv ----
// port-level assertions for the serial RAM streamer
module ssrs_top_chk
    import ssrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic core_ce,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe_n,
    input wire logic data_inout_pin_out,
    input wire logic data_inout_pin_oe_n,
    input wire logic done_irq,
    input wire logic halt_wake
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] baud_q, len_q, ctl_q, cfg_q; // shadows of written registers
    logic [8:0] low_cnt, rises; // clock low length, rises since start
    logic wr_ok;
    assign wr_ok = avs_write && !avs_waitrequest;
    // shadow registers follow completed bus writes
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            {baud_q, len_q, ctl_q, cfg_q} <= 32'h0;
            low_cnt <= 9'h0;
            rises <= 9'h0;
        end else begin
            low_cnt <= serial_clock_pin_out ? 9'h0 : low_cnt + 9'h1;
            if ($rose(serial_clock_pin_out) && !serial_clock_pin_oe_n) rises <= rises + 9'h1;
            if (wr_ok && avs_address == IDX_BAUD) baud_q <= avs_writedata[7:0];
            if (wr_ok && avs_address == IDX_BITLEN) len_q <= avs_writedata[7:0];
            if (wr_ok && avs_address == IDX_PINCFG) cfg_q <= avs_writedata[7:0];
            if (wr_ok && avs_address == IDX_CTRL) begin
                ctl_q <= avs_writedata[7:0];
                rises <= 9'h0;
            end
        end
    end
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest && core_ce |=> !avs_waitrequest)
        else $error("bus access not answered after one wait cycle");
    AST_CLK_HALF: assert property ($rose(serial_clock_pin_out) && !serial_clock_pin_oe_n |-> low_cnt == {1'b0, baud_q} + 9'h1)
        else $error("internal clock low phase length wrong");
    AST_EXT_CLK_IN: assert property (cfg_q[0] && $past(cfg_q[0], 2) |-> serial_clock_pin_oe_n)
        else $error("clock pin driven in external clock mode");
    AST_OD_LOW: assert property (data_inout_pin_out == 1'b0)
        else $error("data line driven high");
    AST_DIO_THREE: assert property (!cfg_q[1] && !$past(cfg_q[1], 2) |-> data_inout_pin_oe_n)
        else $error("data line pulled in three-wire mode");
    AST_WAKE_IRQ: assert property (halt_wake |-> done_irq)
        else $error("wake without completion request");
    AST_CONT_NO_WAKE: assert property (ctl_q[4] && $past(ctl_q[4], 2) |-> !halt_wake)
        else $error("continuous run woke the processor");
    // done and the last clock rise share one edge, so that rise is not yet counted here
    AST_BIT_COUNT: assert property ($rose(done_irq) && !serial_clock_pin_oe_n |->
        rises + 9'h1 == (ctl_q[4] ? {1'b0, len_q} + 9'h1 : 9'h8))
        else $error("wrong number of clocks in run");
    // main scenarios seen
    COV_WAKE: cover property (halt_wake);
    COV_CONT_DONE: cover property ($rose(done_irq) && ctl_q[4]);
    COV_TWO_WIRE: cover property (!data_inout_pin_oe_n);
endmodule : ssrs_top_chk
bind ssrs_top ssrs_top_chk u_ssrs_top_chk (.core_clk(core_clk), .reset_n(reset_n), .core_ce(core_ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .data_inout_pin_out(data_inout_pin_out),
    .data_inout_pin_oe_n(data_inout_pin_oe_n), .done_irq(done_irq), .halt_wake(halt_wake));

// ---- bench/ssrs_top_tb.sv ----
// self-checking bench for the serial RAM streamer
module ssrs_top_tb;
    import ssrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, reset_n = 1'b0, cpu_halt = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [15:0] avs_address = 16'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic p_ld = 1'b0, p_go = 1'b0;
    logic [7:0] p_val = 8'hFF, rd_q, tx_seen = 8'h0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest, sclk_out, sclk_oe_n, dout, dout_oe_n, dio_out, dio_oe_n, done_irq, halt_wake;
    wire logic ext_clk, psd, sclk, dio;
    int err_count = 0, checks_done = 0, cyc = 0;
    logic [15:0] idx [7] = '{IDX_CTRL, IDX_SHIFT, IDX_BAUD, IDX_BITLEN, IDX_STREAM, IDX_PINCFG, 16'h1234};
    // clock pin and open-drain data line levels
    assign sclk = sclk_oe_n ? ext_clk : sclk_out;
    assign dio = psd & (dio_oe_n | dio_out);
    always #5 core_clk = ~core_clk;
    ssrs_top u_ssrs_top (.core_clk(core_clk), .reset_n(reset_n), .core_ce(1'b1), .cpu_halt(cpu_halt),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_clock_pin_in(sclk),
        .serial_clock_pin_out(sclk_out), .serial_clock_pin_oe_n(sclk_oe_n), .data_out_pin(dout),
        .data_out_pin_oe_n(dout_oe_n), .data_inout_pin_in(dio), .data_inout_pin_out(dio_out),
        .data_inout_pin_oe_n(dio_oe_n), .done_irq(done_irq), .halt_wake(halt_wake));
    ssrs_partner u_ssrs_partner (.line_clk(sclk), .ld(p_ld), .go(p_go), .val(p_val), .ext_clk(ext_clk), .sd(psd));
    // bits sent on the output pin, msb first
    always @(posedge sclk_out) begin
        if (!sclk_oe_n) tx_seen <= {tx_seen[6:0], dout};
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one bus access held until waitrequest is seen low
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        rd_q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check($sformatf("reg %h", a), rd_q, exp);
    endtask : rd
    task automatic load(input logic [7:0] v);
        p_val = v;
        p_ld <= 1'b1;
        @(posedge core_clk);
        p_ld <= 1'b0;
    endtask : load
    task automatic wait_irq();
        while (done_irq !== 1'b1) @(posedge core_clk);
    endtask : wait_irq
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        foreach (idx[i]) rd(idx[i], 8'h00);
        $display("test reset done");
        // single byte, internal clock, msb first, processor halted
        wr(IDX_BAUD, 8'h03);
        wr(IDX_SHIFT, 8'h3C);
        load(8'h96);
        cpu_halt <= 1'b1;
        wr(IDX_CTRL, 8'h29);
        wait_irq();
        check("wake", {7'h0, halt_wake}, 8'h01);
        check("sent", tx_seen, 8'h3C);
        rd(IDX_SHIFT, 8'h96);
        rd(IDX_CTRL, 8'h0B);
        $display("test single done");
        // continuous, bank 1, write-back, 20 bits, held by halt then pause
        wr(16'h01E0, 8'h11);
        wr(16'h01E1, 8'h22);
        wr(16'h01E2, 8'h33);
        wr(IDX_BITLEN, 8'h13);
        load(8'h5A);
        wr(IDX_CTRL, 8'hF9);
        repeat (50) @(posedge core_clk);
        rd(IDX_STREAM, 8'h00);
        cpu_halt <= 1'b0;
        wr(IDX_STREAM, 8'h80);
        repeat (150) @(posedge core_clk);
        rd(IDX_STREAM, 8'h81);
        wr(IDX_STREAM, 8'h00);
        wait_irq();
        check("no wake", {7'h0, halt_wake}, 8'h00);
        check("sent tail", tx_seen, 8'h23);
        rd(IDX_STREAM, 8'h03);
        rd(IDX_SHIFT, 8'h35);
        rd(IDX_CTRL, 8'hCB);
        rd(16'h01E0, 8'h96);
        rd(16'h01E1, 8'h5A);
        rd(16'h01E2, 8'h5A);
        rd(16'h01E3, 8'h00);
        $display("test continuous done");
        // external clock, two-wire, copy mode, 5 bits, surplus clocks
        wr(IDX_PINCFG, 8'h03);
        check("dout oe", {7'h0, dout_oe_n}, 8'h01);
        wr(16'h01C0, 8'hC3);
        wr(IDX_BITLEN, 8'h04);
        load(8'hFF);
        wr(IDX_CTRL, 8'h31);
        p_go <= 1'b1;
        wait_irq();
        p_go <= 1'b0;
        repeat (60) @(posedge core_clk);
        rd(IDX_SHIFT, 8'h1E);
        rd(IDX_CTRL, 8'h07);
        rd(16'h01C0, 8'hC3);
        rd(IDX_STREAM, 8'h01);
        $display("test external done");
        close_out();
    end
endmodule : ssrs_top_tb
